// ===== design/event_bus_if.sv
`timescale 1ns/1ns
interface event_bus_if;
    logic [15:0] raw;
    logic user_load;
    logic [3:0] user_code;
    modport src (output raw, output user_load, output user_code);
    modport dst (input raw, input user_load, input user_code);
endinterface : event_bus_if

// ===== design/irq_pair.sv
`timescale 1ns/1ns
`include "irq_status_params.svh"
module irq_pair import irq_status_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    event_bus_if.dst ev,
    input wire logic first_pending,
    input wire logic en_we,
    input wire logic [15:0] en_wdata,
    input wire logic clr,
    output word_t en_q,
    output word_t st_q,
    output logic irq_nxt
);
    word_t st_r;
    word_t en_r;
    word_t st_nxt;
    logic pend;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_r <= `RST_WORD;
        end else if (en_we) begin
            en_r <= en_wdata & `IRQ_EVENT_MASK;
        end
    end

    always_comb begin
        st_nxt = clr ? `RST_WORD : st_r;
        // Set beats clear in the same cycle
        st_nxt = st_nxt | (ev.raw & `IRQ_EVENT_MASK);
        if (ev.user_load) begin
            st_nxt[`IRQ_USER_HI:`IRQ_USER_LO] = ev.user_code;
        end
        st_nxt[`IRQ_SUMMARY] = 1'b0;
        st_nxt[`IRQ_FIRST_REG] = 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= `RST_WORD;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pend = |(st_r & en_r & `IRQ_EVENT_MASK);

    always_comb begin
        st_q = st_r;
        st_q[`IRQ_SUMMARY] = pend;
        st_q[`IRQ_FIRST_REG] = first_pending;
    end

    assign en_q = en_r;
    assign irq_nxt = |(st_nxt & en_r & `IRQ_EVENT_MASK);
endmodule : irq_pair

// ===== design/irq_status_logic.sv
// Overview of operation
// - Protocol self-test flags bits 15..11 read-only; bits 10..8, 4..0 zero.
// - RAM self-test flags: bit 7 done, 6 busy, 5 passed.
// - Enable bit one passes its event to interrupt output; zero masks it.
// - Status bits set on event regardless of enable.
// - Bit 14 flags sequencer instruction parity error.
// - Bit 13 flags illegal command (terminal) or stored message (monitor).
// - Bit 12 flags queue rollover, queue chosen by mode.
// - Bit 11 call stack fault, bit 10 illegal op code, controller mode.
// - Half-full flags: bits 9, 8, 7, 6 for four structures.
// - IRQ instruction loads its low four parameter bits into bits 5..2.
// - Bit 1 flags self-test completion.
// - Bit 15 any enabled pending; bit 0 mirrors first status register.
// - Queue pointer: base bits 15..6, next entry bits 5..0.
// - Message word: bit 14 during message, bit 15 on completion.
// - Bit 13 one for bus B, zero for bus A.
// - Bit 12 set with any error in 10..8; alone means handshake fail.
// - Bit 11 unexpected status bits 10..0; bit 7 unmasked status bit set.
// - Bit 10 protocol violation; bit 9 late response.
// - Loopback word validity or last-word mismatch sets bit 8.
// - Bits 6..5 retries: 00 none, 01 one, 1x two.
// - Bit 3 address mismatch, or gap under 4 us when checking enabled.
// - Bit 2 count error on transmit only; bit 1 sync; bit 0 bad word.
`timescale 1ns/1ns
`include "irq_status_params.svh"
module irq_status_logic import irq_status_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_r,
    input wire logic [1:0] op_mode,
    input wire logic irq_clear,
    input wire logic first_pending,
    input wire logic proto_busy,
    input wire logic proto_pass,
    input wire logic proto_abort,
    input wire logic proto_done,
    input wire logic ram_busy,
    input wire logic ram_pass,
    input wire logic ram_done,
    input wire logic instr_parity_irq,
    input wire logic illegal_command_irq,
    input wire logic queue_rollover_irq,
    input wire logic call_stack_fault_irq,
    input wire logic bad_opcode_irq,
    input wire logic rt_cmd_stack_half_irq,
    input wire logic rt_circ_buf_half_irq,
    input wire logic mon_cmd_stack_half_irq,
    input wire logic mon_data_stack_half_irq,
    input wire logic seq_irq_exec,
    input wire logic [3:0] sequencer_user_irq_code,
    input wire logic selftest_done_irq,
    input wire logic queue_advance,
    input wire logic msg_start,
    input wire logic msg_end,
    input wire logic bus_b_indicator,
    input wire logic msg_is_transmit,
    input wire logic handshake_fail,
    input wire logic [15:0] rt_status_word,
    input wire logic [15:0] expected_status,
    input wire logic [15:0] ctrl_word,
    input wire logic format_err_flag,
    input wire logic reply_valid,
    input wire logic rt_to_rt_late,
    input wire logic loop_word_valid,
    input wire logic loop_word_check,
    input wire logic last_word_mismatch,
    input wire logic [1:0] retry_count,
    input wire logic rt_addr_mismatch,
    input wire logic gap_check_enable,
    input wire logic tx_end,
    input wire logic reply_sync,
    input wire logic word_count_err,
    input wire logic sync_err_flag,
    input wire logic bad_word_flag,
    input wire logic good_data_block,
    output logic irq_out_r,
    output logic msg_word_we_r,
    output logic [15:0] msg_word_r,
    output logic [15:0] queue_pointer_r
);
    event_bus_if ev ();
    word_t en_q;
    word_t st_q;
    logic irq_nxt;
    logic [15:0] selftest_r;
    logic [15:0] msg_nxt;
    logic [15:0] rdata_nxt;
    logic [`GAP_CNT_W-1:0] gap_cnt_r;
    logic gap_run_r;
    logic gap_short;
    logic loop_fail_r;
    logic stat_hit;
    logic mstat_hit;
    logic err_any;
    msg_state_t mstate_r;
    logic is_bc;
    logic is_term;

    assign is_bc = (op_mode == MODE_BC);
    assign is_term = !is_bc;

    // Event map onto the second status register
    always_comb begin
        ev.raw = `RST_WORD;
        ev.raw[`IRQ_INSTR_PAR] = instr_parity_irq & is_bc;
        ev.raw[`IRQ_ILL_CMD] = illegal_command_irq & is_term;
        ev.raw[`IRQ_Q_ROLL] = queue_rollover_irq;
        ev.raw[`IRQ_STACK] = call_stack_fault_irq & is_bc;
        ev.raw[`IRQ_OPCODE] = bad_opcode_irq & is_bc;
        ev.raw[`IRQ_RT_STK] = rt_cmd_stack_half_irq;
        ev.raw[`IRQ_RT_CIRC] = rt_circ_buf_half_irq;
        ev.raw[`IRQ_MON_STK] = mon_cmd_stack_half_irq;
        ev.raw[`IRQ_MON_DATA] = mon_data_stack_half_irq;
        ev.raw[`IRQ_SELFTEST] = selftest_done_irq;
        ev.user_load = seq_irq_exec & is_bc;
        ev.user_code = sequencer_user_irq_code;
    end

    irq_pair u_irq_pair (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ev(ev),
        .first_pending(first_pending),
        .en_we(reg_wr && reg_addr == `ADDR_IRQ_EN2),
        .en_wdata(reg_wdata),
        .clr(irq_clear),
        .en_q(en_q),
        .st_q(st_q),
        .irq_nxt(irq_nxt)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_out_r <= 1'b0;
        end else begin
            irq_out_r <= irq_nxt;
        end
    end

    // Self-test flags, captured each cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            selftest_r <= `RST_WORD;
        end else begin
            selftest_r <= `RST_WORD;
            selftest_r[`ST_PROTO_DONE] <= proto_done;
            selftest_r[`ST_PROTO_BUSY] <= proto_busy;
            selftest_r[`ST_PROTO_PASS] <= proto_pass;
            selftest_r[`ST_PROTO_ABORT] <= proto_abort;
            selftest_r[`ST_PROTO_ANY] <= proto_done | proto_busy;
            selftest_r[`ST_RAM_DONE] <= ram_done;
            selftest_r[`ST_RAM_BUSY] <= ram_busy;
            selftest_r[`ST_RAM_PASS] <= ram_pass;
        end
    end

    // Queue pointer: host write, hardware advances next-entry field
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            queue_pointer_r <= `RST_WORD;
        end else if (reg_wr && reg_addr == `ADDR_QPTR) begin
            queue_pointer_r <= reg_wdata;
        end else if (queue_advance) begin
            queue_pointer_r[`QP_NEXT_HI:`QP_NEXT_LO] <=
                queue_pointer_r[`QP_NEXT_HI:`QP_NEXT_LO] + 6'h01;
        end
    end

    // Read mux, answered one cycle after the read strobe
    always_comb begin
        unique case (reg_addr)
            `ADDR_SELFTEST: rdata_nxt = selftest_r;
            `ADDR_IRQ_EN2: rdata_nxt = en_q;
            `ADDR_IRQ_ST2: rdata_nxt = st_q;
            `ADDR_QPTR: rdata_nxt = queue_pointer_r;
            default: rdata_nxt = `RST_WORD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata_r <= `RST_WORD;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // Response gap timer, from end of transmit to reply sync
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gap_cnt_r <= '0;
            gap_run_r <= 1'b0;
        end else if (tx_end) begin
            gap_cnt_r <= '0;
            gap_run_r <= 1'b1;
        end else if (reply_sync) begin
            gap_run_r <= 1'b0;
        end else if (gap_run_r && gap_cnt_r != {`GAP_CNT_W{1'b1}}) begin
            gap_cnt_r <= gap_cnt_r + `GAP_CNT_W'(1);
        end
    end

    assign gap_short = gap_check_enable && reply_sync && gap_run_r &&
        (gap_cnt_r < `GAP_CNT_W'(`GAP_MIN_CYC - 1));

    // Loopback failures collected over a message
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            loop_fail_r <= 1'b0;
        end else if (msg_start && mstate_r == MSG_IDLE) begin
            loop_fail_r <= 1'b0;
        end else if ((loop_word_check && !loop_word_valid) ||
                     last_word_mismatch) begin
            loop_fail_r <= 1'b1;
        end
    end

    assign stat_hit = reply_valid &&
        ((rt_status_word[`RS_UNEXP_HI:0] ^ expected_status[`RS_UNEXP_HI:0])
         != 11'h000);
    assign mstat_hit = reply_valid &&
        ((rt_status_word[`RS_MASK_HI:`RS_MASK_LO] &
          ~ctrl_word[`RS_MASK_HI:`RS_MASK_LO]) != 6'h00);

    always_comb begin
        msg_nxt = msg_word_r;
        err_any = 1'b0;
        if (msg_start && mstate_r == MSG_IDLE) begin
            msg_nxt = `RST_WORD;
            msg_nxt[`MS_ACTIVE] = 1'b1;
            msg_nxt[`MS_BUS_B] = bus_b_indicator;
        end else if (mstate_r == MSG_RUN) begin
            msg_nxt[`MS_RT_STATUS_UNEXPECTED] = msg_word_r[`MS_RT_STATUS_UNEXPECTED] | stat_hit;
            msg_nxt[`MS_MSTAT] = msg_word_r[`MS_MSTAT] | mstat_hit;
            msg_nxt[`MS_FORMAT] = msg_word_r[`MS_FORMAT] |
                format_err_flag;
            msg_nxt[`MS_TIMEOUT] = msg_word_r[`MS_TIMEOUT] |
                rt_to_rt_late;
            msg_nxt[`MS_ADDR_GAP] = msg_word_r[`MS_ADDR_GAP] |
                (reply_valid & rt_addr_mismatch) | gap_short;
            msg_nxt[`MS_LENGTH] = msg_word_r[`MS_LENGTH] |
                (word_count_err & msg_is_transmit);
            msg_nxt[`MS_SYNC] = msg_word_r[`MS_SYNC] | sync_err_flag;
            msg_nxt[`MS_BADWORD] = msg_word_r[`MS_BADWORD] | bad_word_flag;
            if (msg_end) begin
                msg_nxt[`MS_LOOPBACK] = loop_fail_r |
                    (loop_word_check & !loop_word_valid) |
                    last_word_mismatch;
                err_any = msg_nxt[`MS_FORMAT] | msg_nxt[`MS_TIMEOUT] |
                    msg_nxt[`MS_LOOPBACK];
                msg_nxt[`MS_ERR] = err_any | handshake_fail;
                msg_nxt[`MS_RETRY_HI] = retry_count[1];
                msg_nxt[`MS_RETRY_LO] = retry_count[0] & ~retry_count[1];
                msg_nxt[`MS_GOODDATA] = good_data_block & !err_any;
                msg_nxt[`MS_ACTIVE] = 1'b0;
                msg_nxt[`MS_DONE] = 1'b1;
            end
        end
    end

    // Message word writer: one RAM write at start, one at end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mstate_r <= MSG_IDLE;
            msg_word_r <= `RST_WORD;
            msg_word_we_r <= 1'b0;
        end else begin
            msg_word_r <= msg_nxt;
            msg_word_we_r <= 1'b0;
            unique case (mstate_r)
                MSG_IDLE: begin
                    if (msg_start) begin
                        mstate_r <= MSG_RUN;
                        msg_word_we_r <= 1'b1;
                    end
                end
                MSG_RUN: begin
                    if (msg_end) begin
                        mstate_r <= MSG_WRITE;
                        msg_word_we_r <= 1'b1;
                    end
                end
                MSG_WRITE: begin
                    mstate_r <= MSG_IDLE;
                end
                default: begin
                    mstate_r <= MSG_IDLE;
                end
            endcase
        end
    end
endmodule : irq_status_logic

// ===== design/irq_status_params.svh
`ifndef IRQ_STATUS_PARAMS_SVH
`define IRQ_STATUS_PARAMS_SVH

// Register addresses on the host port
`define ADDR_SELFTEST 8'h1C
`define ADDR_IRQ_EN2 8'h1D
`define ADDR_IRQ_ST2 8'h1E
`define ADDR_QPTR 8'h1F

`define RST_WORD 16'h0000

// Self-test flag positions
`define ST_PROTO_DONE 15
`define ST_PROTO_BUSY 14
`define ST_PROTO_PASS 13
`define ST_PROTO_ABORT 12
`define ST_PROTO_ANY 11
`define ST_RAM_DONE 7
`define ST_RAM_BUSY 6
`define ST_RAM_PASS 5

// Second interrupt register bit positions
`define IRQ_SUMMARY 15
`define IRQ_INSTR_PAR 14
`define IRQ_ILL_CMD 13
`define IRQ_Q_ROLL 12
`define IRQ_STACK 11
`define IRQ_OPCODE 10
`define IRQ_RT_STK 9
`define IRQ_RT_CIRC 8
`define IRQ_MON_STK 7
`define IRQ_MON_DATA 6
`define IRQ_USER_HI 5
`define IRQ_USER_LO 2
`define IRQ_SELFTEST 1
`define IRQ_FIRST_REG 0
`define IRQ_EVENT_MASK 16'h7FFE

// Queue pointer fields
`define QP_BASE_HI 15
`define QP_BASE_LO 6
`define QP_NEXT_HI 5
`define QP_NEXT_LO 0

// Controller message status word positions
`define MS_DONE 15
`define MS_ACTIVE 14
`define MS_BUS_B 13
`define MS_ERR 12
`define MS_RT_STATUS_UNEXPECTED 11
`define MS_FORMAT 10
`define MS_TIMEOUT 9
`define MS_LOOPBACK 8
`define MS_MSTAT 7
`define MS_RETRY_HI 6
`define MS_RETRY_LO 5
`define MS_GOODDATA 4
`define MS_ADDR_GAP 3
`define MS_LENGTH 2
`define MS_SYNC 1
`define MS_BADWORD 0
`define RS_MASK_HI 14
`define RS_MASK_LO 9
`define RS_UNEXP_HI 10

// Response gap figures: minimum gap and clock period in nanoseconds, then minimum in cycles and counter width
`define GAP_MIN_NS 4000
`define CLK_PERIOD_NS 100
`define GAP_MIN_CYC ((`GAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CNT_W 8

`endif

// ===== design/irq_status_pkg.sv
package irq_status_pkg;
    typedef enum logic [1:0] {
        MODE_BC = 2'b00,
        MODE_RT = 2'b01,
        MODE_MON = 2'b10,
        MODE_RTMON = 2'b11
    } op_mode_t;

    typedef enum logic [1:0] {
        MSG_IDLE = 2'b00,
        MSG_RUN = 2'b01,
        MSG_WRITE = 2'b10
    } msg_state_t;

    typedef logic [15:0] word_t;
endpackage : irq_status_pkg

// ===== sim/host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end

    // One access held over one rising edge, then released
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask : xfer
endmodule : host_model

// ===== sim/irq_status_chk.sv
`timescale 1ns/1ns
module irq_status_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_r,
    input wire logic [1:0] op_mode,
    input wire logic instr_parity_irq,
    input wire logic queue_advance,
    input wire logic msg_start,
    input wire logic msg_end,
    input wire logic bus_b_indicator,
    input wire logic irq_out_r,
    input wire logic msg_word_we_r,
    input wire logic [15:0] msg_word_r,
    input wire logic [15:0] queue_pointer_r
);
    logic [15:0] en_r;
    logic run_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Shadow of the writable enable bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) en_r <= 16'h0000;
        else if (reg_wr && reg_addr == 8'h1D) en_r <= reg_wdata & 16'h7FFE;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) run_r <= 1'b0;
        else if (msg_start && !run_r) run_r <= 1'b1;
        else if (msg_end && run_r) run_r <= 1'b0;
    end

    a_irq_masked: assert property ((en_r == 16'h0000) &&
        !(reg_wr && reg_addr == 8'h1D) |=> !irq_out_r)
        else $error("interrupt raised with all enables clear");
    a_irq_parity: assert property (en_r[14] && op_mode == 2'h0 &&
        instr_parity_irq && !reg_wr |=> irq_out_r)
        else $error("enabled parity event gave no interrupt");
    a_qptr_wrap: assert property (queue_advance && !reg_wr |=>
        $stable(queue_pointer_r[15:6]) &&
        queue_pointer_r[5:0] == $past(queue_pointer_r[5:0]) + 6'h01)
        else $error("queue pointer advance wrong");
    a_qptr_write: assert property (reg_wr && reg_addr == 8'h1F &&
        !queue_advance |=> queue_pointer_r == $past(reg_wdata))
        else $error("queue pointer write lost");
    a_msg_open: assert property (msg_start && !run_r |=>
        msg_word_we_r && msg_word_r[15:14] == 2'h1 &&
        msg_word_r[13] == $past(bus_b_indicator))
        else $error("start word wrong");
    a_msg_close: assert property (msg_end && run_r |=>
        msg_word_we_r && msg_word_r[15:14] == 2'h2)
        else $error("end word wrong");
    a_err_summary: assert property (msg_word_we_r &&
        (|msg_word_r[10:8]) |-> msg_word_r[12])
        else $error("error summary missing");
    a_selftest_zero: assert property (reg_rd && reg_addr == 8'h1C |=>
        reg_rdata_r[10:8] == 3'h0 && reg_rdata_r[4:0] == 5'h00)
        else $error("self-test zero bits set");
endmodule : irq_status_chk

bind irq_status_logic irq_status_chk chk (.sys_clk, .rst_n, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .op_mode, .instr_parity_irq,
    .queue_advance, .msg_start, .msg_end, .bus_b_indicator, .irq_out_r,
    .msg_word_we_r, .msg_word_r, .queue_pointer_r);

// ===== sim/irq_status_logic_tb.sv
`timescale 1ns/1ns
module irq_status_logic_tb import irq_status_pkg::*;;
    logic sys_clk, rst_n, reg_wr, reg_rd, irq_out_r, msg_word_we_r, rd_seen;
    logic clr, fp, sx, qa, ms, me, txe, rsy, rv, lchk, ok, lb;
    logic [7:0] reg_addr;
    logic [1:0] op_mode, ret;
    logic [15:0] reg_wdata, reg_rdata_r, msg_word_r, queue_pointer_r;
    logic [15:0] rts, exps, cw, w;
    logic [6:0] st_v;
    logic [9:0] ev_v;
    logic [12:0] m_v;
    logic [3:0] uc;
    word_t rd_q[$], mq[$];
    int fails, n_compared;
    integer seed = 60046;

    host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    irq_status_logic dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .op_mode(op_mode),
        .irq_clear(clr), .first_pending(fp), .proto_busy(st_v[5]),
        .proto_pass(st_v[4]), .proto_abort(st_v[3]), .proto_done(st_v[6]),
        .ram_busy(st_v[1]), .ram_pass(st_v[0]), .ram_done(st_v[2]),
        .instr_parity_irq(ev_v[8]), .illegal_command_irq(ev_v[7]),
        .queue_rollover_irq(ev_v[6]), .call_stack_fault_irq(ev_v[5]),
        .bad_opcode_irq(ev_v[4]), .rt_cmd_stack_half_irq(ev_v[3]),
        .rt_circ_buf_half_irq(ev_v[2]), .mon_cmd_stack_half_irq(ev_v[1]),
        .mon_data_stack_half_irq(ev_v[0]), .seq_irq_exec(sx),
        .sequencer_user_irq_code(uc), .selftest_done_irq(ev_v[9]),
        .queue_advance(qa), .msg_start(ms), .msg_end(me),
        .bus_b_indicator(m_v[0]), .msg_is_transmit(m_v[1]),
        .handshake_fail(m_v[3]), .rt_status_word(rts),
        .expected_status(exps), .ctrl_word(cw), .format_err_flag(m_v[4]),
        .reply_valid(rv), .rt_to_rt_late(m_v[5]), .loop_word_valid(m_v[6]),
        .loop_word_check(lchk), .last_word_mismatch(m_v[7]),
        .retry_count(ret), .rt_addr_mismatch(m_v[8]),
        .gap_check_enable(m_v[2]), .tx_end(txe), .reply_sync(rsy),
        .word_count_err(m_v[9]), .sync_err_flag(m_v[10]),
        .bad_word_flag(m_v[11]), .good_data_block(m_v[12]),
        .irq_out_r(irq_out_r), .msg_word_we_r(msg_word_we_r),
        .msg_word_r(msg_word_r), .queue_pointer_r(queue_pointer_r));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic note(input string nm, input logic good, input word_t e,
                        input word_t s);
        n_compared++;
        if (!good) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : note

    task automatic chk_rd(input word_t e, input word_t s);
        note("reg_rdata_r", s === e, e, s);
    endtask : chk_rd

    // Good-data flag left out of the message word compare
    task automatic chk_msg(input word_t e, input word_t s);
        note("msg_word_r", (s & 16'hFFEF) === (e & 16'hFFEF), e, s);
    endtask : chk_msg

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task automatic rd(input logic [7:0] a, input word_t e);
        rd_q.push_back(e);
        host.xfer(1'b0, a, 16'h0000);
    endtask : rd

    task automatic clear();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask : clear

    task automatic msg(input int gap);
        logic [15:0] r;
        r = $random(seed);
        rts = $random(seed);
        exps = r[15] ? rts : rts ^ (16'h0001 << r[14:12]);
        cw = {1'b0, r[10:5], 9'h000};
        m_v[2:0] = r[2:0];
        ret = r[4:3];
        ms = 1'b1;
        txe = 1'b1;
        mq.push_back({2'h1, r[0], 13'h0000});
        cyc(1);
        ms = 1'b0;
        txe = 1'b0;
        cyc(gap - 1);
        rsy = 1'b1;
        rv = 1'b1;
        lchk = 1'b1;
        m_v[12:3] = $random(seed);
        cyc(1);
        rsy = 1'b0;
        rv = 1'b0;
        lchk = 1'b0;
        cyc(2);
        me = 1'b1;
        lb = ~m_v[6] | m_v[7];
        mq.push_back({2'h2, m_v[0], m_v[4] | m_v[5] | lb | m_v[3], ~r[15],
            m_v[4], m_v[5], lb, |(rts[14:9] & ~r[10:5]),
            ret == 2'h3 ? 2'h2 : ret, 1'b0,
            m_v[8] | (m_v[2] && gap < 40), m_v[9] & m_v[1], m_v[10],
            m_v[11]});
        cyc(1);
        me = 1'b0;
        m_v = 13'h0000;
        ret = 2'h0;
        cyc(2);
    endtask : msg

    task automatic complete_run();
        if (rd_q.size() != 0 || mq.size() != 0) fails++;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) rd_seen <= reg_rd & rst_n;

    always @(negedge sys_clk) begin
        if (rd_seen === 1'b1) begin
            chk_rd(rd_q.size() ? rd_q.pop_front() : 16'hDEAD, reg_rdata_r);
        end
        if (msg_word_we_r === 1'b1) begin
            chk_msg(mq.size() ? mq.pop_front() : 16'hDEAD, msg_word_r);
        end
    end

    initial begin
        {rst_n, rd_seen, clr, fp, sx, qa, ms, me, txe, rsy, rv, lchk} = 0;
        {op_mode, ret, rts, exps, cw, st_v, ev_v, m_v, uc} = 0;
        cyc(10);
        rst_n = 1'b1;
        for (int a = 28; a < 33; a++) rd(8'(a), 16'h0000);
        host.xfer(1'b1, 8'h1D, 16'hFFFF);
        rd(8'h1D, 16'h7FFE);
        host.xfer(1'b1, 8'h1E, 16'hFFFF);
        host.xfer(1'b1, 8'h1C, 16'hFFFF);
        rd(8'h1E, 16'h0000);
        rd(8'h1C, 16'h0000);
        host.xfer(1'b1, 8'h1D, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            st_v = 7'($random(seed));
            cyc(2);
            rd(8'h1C, {st_v[6:3], st_v[6] | st_v[5], 3'h0, st_v[2:0],
                5'h00});
        end
        for (int m = 0; m < 4; m++) begin
            op_mode = op_mode_t'(m);
            for (int i = 0; i < 10; i++) begin
                ev_v = 10'h001 << i;
                cyc(1);
                ev_v = 10'h000;
                ok = !(m != 0 && (i == 8 || i == 5 || i == 4)) &&
                    !(m == 0 && i == 7);
                rd(8'h1E, ok ? 16'h0001 << (i == 9 ? 1 : i + 6) :
                    16'h0000);
                clear();
            end
        end
        op_mode = MODE_BC;
        host.xfer(1'b1, 8'h1D, 16'h4002);
        ev_v = 10'h100;
        cyc(1);
        ev_v = 10'h200;
        cyc(1);
        ev_v = 10'h000;
        rd(8'h1E, 16'hC002);
        rd(8'h1E, 16'hC002);
        clear();
        rd(8'h1E, 16'h0000);
        host.xfer(1'b1, 8'h1D, 16'h003C);
        uc = 4'($random(seed)) | 4'h1;
        sx = 1'b1;
        cyc(1);
        sx = 1'b0;
        rd(8'h1E, {1'b1, 9'h000, uc, 2'h0});
        clear();
        fp = 1'b1;
        cyc(1);
        rd(8'h1E, 16'h0001);
        fp = 1'b0;
        cyc(1);
        rd(8'h1E, 16'h0000);
        host.xfer(1'b1, 8'h1F, 16'hABFF);
        qa = 1'b1;
        cyc(1);
        qa = 1'b0;
        rd(8'h1F, 16'hABC0);
        for (int k = 0; k < 4; k++) begin
            w = $random(seed);
            host.xfer(1'b1, 8'h1F, w);
            rd(8'h1F, w);
        end
        for (int k = 0; k < 8; k++) msg(k[0] ? 20 : 60);
        cyc(4);
        complete_run();
    end
endmodule : irq_status_logic_tb
